// ### dsfi_asserts.sv
// Link protocol checker for the serial frame interface.
`timescale 1ns/1ps
module dsfi_asserts #(
	parameter int SCLK_HALF = 2,
	parameter int CAL_WAIT_CYC = 50
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic sdi,
	input wire logic load_strobe_n,
	input wire logic reset_pin_n,
	input wire logic voltage_en,
	input wire logic current_en
);
	// ********************
	// Frame tracking.
	// ********************
	localparam int RST_MIN = 2496;
	localparam int CAL_MIN = CAL_WAIT_CYC - 4;
	logic [5:0] fall_reg;
	logic [31:0] word_reg;
	logic [15:0] quiet_reg;
	logic [1:0] last_reg;

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fall_reg <= 6'h00;
			word_reg <= 32'h0;
		end else if (cs_n) begin
			fall_reg <= 6'h00;
		end else if ($fell(sclk)) begin
			fall_reg <= fall_reg + 6'h01;
			word_reg <= {word_reg[30:0], sdi};
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			quiet_reg <= 16'h0000;
		else if (!reset_pin_n || !cs_n)
			quiet_reg <= 16'h0000;
		else if (quiet_reg != 16'hFFFF)
			quiet_reg <= quiet_reg + 16'h0001;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			last_reg <= 2'h1;
		else if (!reset_pin_n)
			last_reg <= 2'h1;
		else if ($rose(cs_n)) begin
			if (word_reg[28:24] != 5'h06)
				last_reg <= 2'h0;
			else if (word_reg[23:8] == 16'hA55A)
				last_reg <= 2'h1;
			else if (word_reg[23:8] == 16'h5AA5)
				last_reg <= 2'h2;
			else
				last_reg <= 2'h0;
		end
	end

	sequence frame_open;
		$fell(cs_n) ##0 !sclk;
	endsequence

	sequence last_fall;
		$fell(sclk) ##0 (fall_reg == 6'h1F);
	endsequence

	sclk_idle_low_a: assert property (cs_n |-> !sclk)
		else $error("serial clock not low between frames");
	sample_stable_a: assert property (
		$fell(sclk) |-> $stable(sdi) && !cs_n)
		else $error("data moved at sampling edge");
	frame_length_a: assert property (
		$rose(cs_n) |-> fall_reg == 6'h20)
		else $error("frame not 32 clock falls");
	frame_start_a: assert property (
		frame_open |-> ##SCLK_HALF $rose(sclk))
		else $error("first clock rise late or early");
	high_half_a: assert property (
		$rose(sclk) |-> ##SCLK_HALF $fell(sclk))
		else $error("clock high phase wrong");
	frame_close_a: assert property (
		last_fall |-> ##SCLK_HALF $rose(cs_n))
		else $error("select not released after last bit");
	reset_quiet_a: assert property (
		$fell(cs_n) && last_reg == 2'h1 |-> quiet_reg >= RST_MIN)
		else $error("frame too soon after reset");
	cal_quiet_a: assert property (
		$fell(cs_n) && last_reg == 2'h2 |-> quiet_reg >= CAL_MIN)
		else $error("frame too soon after refresh");
	outputs_exclusive_a: assert property (
		!(voltage_en && current_en))
		else $error("both outputs enabled");
	reset_disables_a: assert property (
		!reset_pin_n |-> !voltage_en && !current_en)
		else $error("output enabled in reset");
endmodule

// ### dsfi_device.sv
// Device end: frame receiver, configuration registers and reset control.
// What this block does
// - CRC on: 32-bit frames, MSB first.
// - Sample serial data on falling clock edge.
// - CRC off: 24-bit word, last 8 ignored.
// - Frame: slip, address, register, data, check.
// - Straight binary codes; bipolar midscale gives zero.
// - Only one of current or voltage enabled.
// - Six selectable current ranges.
// - Four selectable voltage ranges.
// - Voltage overrange and negative unipolar offset options.
// - Both output channels disabled after reset.
// - Pull-down switch open after reset, configurable.
// - Host issues calibration refresh, waits 500 us.
// - Held in reset while supplies too low.
// - Reset pin resets fully; software command keeps the CRC error flag and refresh toggle.
// - Host sends nothing within 100 us of reset.
// - Programmed supply level in converter field 4:0.
// - Output register frozen while load strobe high.
`timescale 1ns/1ps
`include "dsfi_regs.svh"
module dsfi_device #(
	parameter logic [7:0] CRC_POLY = `DSFI_CRC_POLY
) (
	dsfi_if.device link,
	input wire logic [1:0] dev_addr,
	input wire logic supply_ok,
	output logic [15:0] dac_code,
	output logic [15:0] output_level,
	output logic voltage_en,
	output logic current_en,
	output dsfi_pkg::dsfi_range_type out_range,
	output logic overrange_en,
	output logic neg_offset_en,
	output logic pulldown_closed,
	output logic [4:0] supply_level,
	output logic programmed_supply_mode,
	output logic crc_disabled,
	output logic crc_error,
	output logic cal_refresh_toggle
);
	import dsfi_pkg::*;

	// ****************************************************************
	// Reset and frame framing.
	// ****************************************************************
	logic rst_n;
	logic frame_rst_n;
	logic [5:0] bit_cnt_reg;
	logic [30:0] shift_reg;
	logic [7:0] crc_reg;
	logic [31:0] word32;
	logic [23:0] hdr;
	logic [15:0] data;
	logic [4:0] reg_addr;
	logic commit;
	logic done_reg;
	logic crc_ok;
	logic accept;
	logic sw_reset;
	logic crc_fb;
	logic ld_sync1_reg;
	logic ld_sync2_reg;
	logic [15:0] dac_input_reg;
	logic bipolar_reg;
	logic is_voltage;
	logic is_current;
	logic is_bipolar;

	assign rst_n = supply_ok & link.reset_pin_n;
	assign frame_rst_n = rst_n & ~link.cs_n;

	// Bit counter stops after the 32nd edge so later bits do nothing.
	always_ff @(negedge link.sclk or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			bit_cnt_reg <= 6'h00;
		end else if (bit_cnt_reg != `DSFI_CNT_STOP) begin
			bit_cnt_reg <= bit_cnt_reg + 6'h01;
		end
	end

	always_ff @(negedge link.sclk or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			shift_reg <= 31'h00000000;
		end else begin
			shift_reg <= {shift_reg[29:0], link.sdi};
		end
	end

	assign crc_fb = crc_reg[7] ^ link.sdi;

	// Serial check byte over the first 24 bits of the frame.
	always_ff @(negedge link.sclk or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			crc_reg <= 8'h00;
		end else if (bit_cnt_reg < `DSFI_CRC_BITS) begin
			crc_reg <= {crc_reg[6:0], 1'b0} ^ (crc_fb ? CRC_POLY : 8'h00);
		end
	end

	// One commit per frame, even when the frame itself changes the mode.
	always_ff @(negedge link.sclk or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			done_reg <= 1'b0;
		end else if (commit) begin
			done_reg <= 1'b1;
		end
	end

	// ****************************************************************
	// Frame decode.
	// ****************************************************************
	assign word32 = {shift_reg, link.sdi};
	assign commit = !done_reg && (crc_disabled
		? (bit_cnt_reg == `DSFI_SHORT_LAST)
		: (bit_cnt_reg == `DSFI_FRAME_LAST));
	assign hdr = crc_disabled ? word32[23:0] : word32[31:8];
	assign data = hdr[15:0];
	assign reg_addr = hdr[`DSFI_HDR_REG_MSB:`DSFI_HDR_REG_LSB];
	assign crc_ok = crc_disabled || (word32[7:0] == crc_reg);
	assign accept = commit && crc_ok
		&& (hdr[`DSFI_HDR_ADDR_MSB:`DSFI_HDR_ADDR_LSB] == dev_addr);
	assign sw_reset = accept && (reg_addr == `DSFI_REG_COMMAND)
		&& (data == `DSFI_KEY_SW_RESET);

	assign is_voltage = data[3:0] <= DSFI_V_PM10;
	assign is_current = (data[3:0] >= DSFI_I_0_20)
		&& (data[3:0] <= DSFI_I_M1_22);
	assign is_bipolar = (data[3:0] == DSFI_V_PM5)
		|| (data[3:0] == DSFI_V_PM10) || (data[3:0] == DSFI_I_PM20)
		|| (data[3:0] == DSFI_I_PM24);

	// ****************************************************************
	// Configuration registers.
	// ****************************************************************
	always_ff @(negedge link.sclk or negedge rst_n) begin
		if (!rst_n) begin
			out_range <= DSFI_V_0_5;
			voltage_en <= 1'b0;
			current_en <= 1'b0;
			overrange_en <= 1'b0;
			bipolar_reg <= 1'b0;
		end else if (sw_reset) begin
			out_range <= DSFI_V_0_5;
			voltage_en <= 1'b0;
			current_en <= 1'b0;
			overrange_en <= 1'b0;
			bipolar_reg <= 1'b0;
		end else if (accept && reg_addr == `DSFI_REG_OUT_CONFIG) begin
			out_range <= dsfi_range_type'(data[3:0]);
			// A single enable steered by range keeps the modes exclusive.
			voltage_en <= data[`DSFI_CFG_EN_BIT] && is_voltage;
			current_en <= data[`DSFI_CFG_EN_BIT] && is_current;
			overrange_en <= data[`DSFI_CFG_OVR_BIT] && is_voltage;
			bipolar_reg <= is_bipolar;
		end
	end

	always_ff @(negedge link.sclk or negedge rst_n) begin
		if (!rst_n) begin
			supply_level <= `DSFI_RST_LEVEL;
			programmed_supply_mode <= 1'b0;
		end else if (sw_reset) begin
			supply_level <= `DSFI_RST_LEVEL;
			programmed_supply_mode <= 1'b0;
		end else if (accept && reg_addr == `DSFI_REG_CONV_ONE) begin
			supply_level <= data[4:0];
			programmed_supply_mode <= data[`DSFI_CONV1_PPC_BIT];
		end
	end

	always_ff @(negedge link.sclk or negedge rst_n) begin
		if (!rst_n) begin
			pulldown_closed <= 1'b0;
		end else if (sw_reset) begin
			pulldown_closed <= 1'b0;
		end else if (accept && reg_addr == `DSFI_REG_CONV_TWO) begin
			pulldown_closed <= data[`DSFI_CONV2_PULLDOWN_BIT];
		end
	end

	always_ff @(negedge link.sclk or negedge rst_n) begin
		if (!rst_n) begin
			crc_disabled <= 1'b0;
			neg_offset_en <= 1'b0;
		end else if (sw_reset) begin
			crc_disabled <= 1'b0;
			neg_offset_en <= 1'b0;
		end else if (accept && reg_addr == `DSFI_REG_GENERAL_ONE) begin
			crc_disabled <= data[`DSFI_GEN1_CRC_OFF_BIT];
			neg_offset_en <= data[`DSFI_GEN1_NEG_OFS_BIT];
		end
	end

	// Calibration refresh is reported as a toggle for the analog side.
	always_ff @(negedge link.sclk or negedge rst_n) begin
		if (!rst_n) begin
			cal_refresh_toggle <= 1'b0;
		end else if (accept && reg_addr == `DSFI_REG_COMMAND
			&& data == `DSFI_KEY_CAL_REFRESH) begin
			cal_refresh_toggle <= ~cal_refresh_toggle;
		end
	end

	// Error flag is set by a bad frame and cleared by a good one.
	always_ff @(negedge link.sclk or negedge rst_n) begin
		if (!rst_n) begin
			crc_error <= 1'b0;
		end else if (commit && !crc_disabled) begin
			crc_error <= !crc_ok;
		end
	end

	// ****************************************************************
	// Input and output code registers.
	// ****************************************************************
	always_ff @(negedge link.sclk or negedge rst_n) begin
		if (!rst_n) begin
			dac_input_reg <= `DSFI_RST_CODE;
		end else if (sw_reset) begin
			dac_input_reg <= `DSFI_RST_CODE;
		end else if (accept && reg_addr == `DSFI_REG_DAC_INPUT) begin
			dac_input_reg <= data;
		end
	end

	always_ff @(negedge link.sclk or negedge rst_n) begin
		if (!rst_n) begin
			ld_sync1_reg <= 1'b1;
			ld_sync2_reg <= 1'b1;
		end else begin
			ld_sync1_reg <= link.load_strobe_n;
			ld_sync2_reg <= ld_sync1_reg;
		end
	end

	always_ff @(negedge link.sclk or negedge rst_n) begin
		if (!rst_n) begin
			dac_code <= `DSFI_RST_CODE;
		end else if (sw_reset) begin
			dac_code <= `DSFI_RST_CODE;
		end else if (!ld_sync2_reg) begin
			dac_code <= dac_input_reg;
		end
	end

	// Bipolar ranges flip the top bit to give a signed level.
	assign output_level = {dac_code[15] ^ bipolar_reg, dac_code[14:0]};

endmodule

// ### dsfi_host.sv
// Controller end: AHB-Lite registers, frame sender and reset guard timing.
`timescale 1ns/1ps
`include "dsfi_regs.svh"
module dsfi_host #(
	parameter int CAL_WAIT_CYC = `DSFI_CAL_WAIT_CYC,
	parameter int SCLK_HALF = `DSFI_SCLK_HALF,
	parameter logic [7:0] CRC_POLY = `DSFI_CRC_POLY
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	dsfi_if.host link
);
	import dsfi_pkg::*;

	// ****************************************************************
	// Register bus.
	// ****************************************************************
	logic wr_pend_reg;
	logic [7:0] addr_reg;
	logic [3:0] ctrl_reg;
	logic [23:0] tx_word_reg;
	logic start_reg;
	dsfi_state_type state_reg;
	logic [13:0] guard_reg;
	logic [7:0] div_reg;
	logic [31:0] out_reg;
	logic [5:0] sent_reg;
	logic sclk_reg;
	logic tick;
	logic busy;
	logic is_reset_cmd;
	logic is_cal_cmd;

	function automatic logic [7:0] crc8(input logic [23:0] w);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 23; i >= 0; i--) begin
			c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? CRC_POLY : 8'h00);
		end
		return c;
	endfunction

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign busy = (state_reg != DSFI_IDLE) || (guard_reg != 14'h0000);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			addr_reg <= 8'h00;
			hrdata <= 32'h00000000;
		end else begin
			wr_pend_reg <= hsel && hready && htrans[1] && hwrite;
			if (hsel && hready && htrans[1]) begin
				addr_reg <= haddr[7:0];
				if (!hwrite) begin
					case (haddr[7:0])
						`DSFI_AHB_CTRL: hrdata <= {28'h0000000, ctrl_reg};
						`DSFI_AHB_TX_WORD: hrdata <= {8'h00, tx_word_reg};
						`DSFI_AHB_STATUS: hrdata <= {31'h00000000, busy};
						default: hrdata <= 32'h00000000;
					endcase
				end
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_reg <= `DSFI_CTRL_RST_VAL;
			tx_word_reg <= 24'h000000;
			start_reg <= 1'b0;
		end else begin
			start_reg <= 1'b0;
			if (wr_pend_reg && addr_reg == `DSFI_AHB_CTRL) begin
				ctrl_reg <= hwdata[3:0] & 4'hD;
				start_reg <= hwdata[`DSFI_CTRL_START_BIT];
			end
			if (wr_pend_reg && addr_reg == `DSFI_AHB_TX_WORD) begin
				tx_word_reg <= hwdata[23:0];
			end
		end
	end

	// ****************************************************************
	// Frame sender and guard timer.
	// ****************************************************************
	assign tick = (div_reg == 8'(SCLK_HALF - 1));
	assign is_reset_cmd = (out_reg[28:24] == `DSFI_REG_COMMAND)
		&& (out_reg[23:8] == `DSFI_KEY_SW_RESET);
	assign is_cal_cmd = (out_reg[28:24] == `DSFI_REG_COMMAND)
		&& (out_reg[23:8] == `DSFI_KEY_CAL_REFRESH);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div_reg <= 8'h00;
		end else if (state_reg == DSFI_IDLE || tick) begin
			div_reg <= 8'h00;
		end else begin
			div_reg <= div_reg + 8'h01;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg <= DSFI_IDLE;
			out_reg <= 32'h00000000;
			sent_reg <= 6'h00;
			sclk_reg <= 1'b0;
			link.sdi <= 1'b0;
			link.cs_n <= 1'b1;
		end else begin
			case (state_reg)
				DSFI_IDLE: begin
					// Requests during the guard time are dropped.
					if (start_reg && !busy) begin
						out_reg <= {tx_word_reg, ctrl_reg[0]
							? crc8(tx_word_reg) : 8'h00};
						link.sdi <= tx_word_reg[23];
						link.cs_n <= 1'b0;
						sent_reg <= 6'h00;
						state_reg <= DSFI_SHIFT;
					end
				end
				DSFI_SHIFT: begin
					if (tick) begin
						sclk_reg <= ~sclk_reg;
						if (!sclk_reg) begin
							link.sdi <= out_reg[31 - sent_reg[4:0]];
						end else if (sent_reg == `DSFI_FRAME_LAST) begin
							state_reg <= DSFI_END;
						end else begin
							sent_reg <= sent_reg + 6'h01;
						end
					end
				end
				DSFI_END: begin
					if (tick) begin
						link.cs_n <= 1'b1;
						state_reg <= DSFI_GUARD;
					end
				end
				DSFI_GUARD: state_reg <= DSFI_IDLE;
				default: state_reg <= DSFI_IDLE;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			guard_reg <= 14'(`DSFI_RESET_WAIT_CYC);
		end else if (ctrl_reg[`DSFI_CTRL_RESET_BIT]) begin
			guard_reg <= 14'(`DSFI_RESET_WAIT_CYC);
		end else if (state_reg == DSFI_GUARD && is_reset_cmd) begin
			guard_reg <= 14'(`DSFI_RESET_WAIT_CYC);
		end else if (state_reg == DSFI_GUARD && is_cal_cmd) begin
			guard_reg <= 14'(CAL_WAIT_CYC);
		end else if (guard_reg != 14'h0000) begin
			guard_reg <= guard_reg - 14'h0001;
		end
	end

	assign link.sclk = sclk_reg;
	assign link.reset_pin_n = ~ctrl_reg[`DSFI_CTRL_RESET_BIT];
	assign link.load_strobe_n = ctrl_reg[`DSFI_CTRL_LOAD_BIT];

endmodule

// ### dsfi_if.sv
// Three-wire link plus strobe and reset pins between controller and device.
`timescale 1ns/1ps
interface dsfi_if;
	logic sclk;
	logic cs_n;
	logic sdi;
	logic load_strobe_n;
	logic reset_pin_n;

	modport device (
		input sclk,
		input cs_n,
		input sdi,
		input load_strobe_n,
		input reset_pin_n
	);

	modport host (
		output sclk,
		output cs_n,
		output sdi,
		output load_strobe_n,
		output reset_pin_n
	);
endinterface

// ### dsfi_pkg.sv
// Types shared by both ends of the serial frame interface.
package dsfi_pkg;

	typedef enum logic [3:0] {
		DSFI_V_0_5 = 4'h0,
		DSFI_V_PM5 = 4'h1,
		DSFI_V_0_10 = 4'h2,
		DSFI_V_PM10 = 4'h3,
		DSFI_I_0_20 = 4'h4,
		DSFI_I_0_24 = 4'h5,
		DSFI_I_4_20 = 4'h6,
		DSFI_I_PM20 = 4'h7,
		DSFI_I_PM24 = 4'h8,
		DSFI_I_M1_22 = 4'h9
	} dsfi_range_type;

	typedef enum logic [1:0] {
		DSFI_IDLE = 2'h0,
		DSFI_SHIFT = 2'h1,
		DSFI_END = 2'h3,
		DSFI_GUARD = 2'h2
	} dsfi_state_type;

endpackage

// ### dsfi_regs.svh
// Constants for the serial frame interface: frame layout, maps, timing.
`ifndef DSFI_REGS_SVH
`define DSFI_REGS_SVH

// ****************************************************************
// Frame layout.
// ****************************************************************
`define DSFI_FRAME_LAST 6'h1F
`define DSFI_SHORT_LAST 6'h17
`define DSFI_CRC_BITS 6'h18
`define DSFI_CNT_STOP 6'h20
`define DSFI_CRC_POLY 8'h07
`define DSFI_HDR_ADDR_MSB 22
`define DSFI_HDR_ADDR_LSB 21
`define DSFI_HDR_REG_MSB 20
`define DSFI_HDR_REG_LSB 16

// ****************************************************************
// Device register addresses and keys.
// ****************************************************************
`define DSFI_REG_DAC_INPUT 5'h01
`define DSFI_REG_OUT_CONFIG 5'h02
`define DSFI_REG_CONV_ONE 5'h03
`define DSFI_REG_CONV_TWO 5'h04
`define DSFI_REG_GENERAL_ONE 5'h05
`define DSFI_REG_COMMAND 5'h06
`define DSFI_KEY_SW_RESET 16'hA55A
`define DSFI_KEY_CAL_REFRESH 16'h5AA5

// ****************************************************************
// Device register fields and reset values.
// ****************************************************************
`define DSFI_CFG_OVR_BIT 4
`define DSFI_CFG_EN_BIT 8
`define DSFI_CONV1_PPC_BIT 5
`define DSFI_CONV2_PULLDOWN_BIT 0
`define DSFI_GEN1_CRC_OFF_BIT 0
`define DSFI_GEN1_NEG_OFS_BIT 1
`define DSFI_RST_CODE 16'h0000
`define DSFI_RST_LEVEL 5'h00

// ****************************************************************
// Controller register offsets and fields.
// ****************************************************************
`define DSFI_AHB_CTRL 8'h00
`define DSFI_AHB_TX_WORD 8'h04
`define DSFI_AHB_STATUS 8'h08
`define DSFI_CTRL_CRC_EN_BIT 0
`define DSFI_CTRL_START_BIT 1
`define DSFI_CTRL_RESET_BIT 2
`define DSFI_CTRL_LOAD_BIT 3
`define DSFI_CTRL_RST_VAL 4'hD

// ****************************************************************
// Timing.
// ****************************************************************
`define DSFI_HCLK_MHZ 25
`define DSFI_T_RESET_US 100
`define DSFI_T_CAL_US 500
`define DSFI_RESET_WAIT_CYC (`DSFI_T_RESET_US * `DSFI_HCLK_MHZ)
`define DSFI_CAL_WAIT_CYC (`DSFI_T_CAL_US * `DSFI_HCLK_MHZ)
`define DSFI_SCLK_HALF 2

`endif

// ### dsfi_unused_note_placeholder.sv
// Empty compilation unit kept for the multi-file layout; holds no logic.
`timescale 1ns/1ps

// ### testbench.sv
// Self-checking bench joining controller and device over the link.
`timescale 1ns/1ps
`include "dsfi_regs.svh"
module testbench;
	import dsfi_pkg::*;
	// ********************
	// Signals and ends.
	// ********************
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic hsel = 1'b1;
	logic [2:0] hsize = 3'h0;
	logic hreadyout, hresp;
	logic [31:0] hrdata, ctl, rd;
	logic [1:0] dev_addr = 2'h0;
	logic [1:0] da;
	logic supply_ok = 1'b1;
	logic [15:0] dac_code, output_level, c, d;
	logic voltage_en, current_en, overrange_en, neg_offset_en, pulldown_closed;
	logic programmed_supply_mode, crc_disabled, crc_error, cal_refresh_toggle;
	logic [4:0] supply_level, lv;
	dsfi_range_type out_range;
	int n_mismatch = 0;
	int n_tests = 0;
	dsfi_if link_bus();

	dsfi_host #(.CAL_WAIT_CYC(50), .SCLK_HALF(2)) dsfi_host_inst (.hclk(hclk),
		.hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .link(link_bus));
	dsfi_device dsfi_device_inst (.link(link_bus), .dev_addr(dev_addr),
		.supply_ok(supply_ok), .dac_code(dac_code), .output_level(output_level),
		.voltage_en(voltage_en), .current_en(current_en), .out_range(out_range),
		.overrange_en(overrange_en), .neg_offset_en(neg_offset_en),
		.pulldown_closed(pulldown_closed), .supply_level(supply_level),
		.programmed_supply_mode(programmed_supply_mode),
		.crc_disabled(crc_disabled), .crc_error(crc_error),
		.cal_refresh_toggle(cal_refresh_toggle));
	dsfi_asserts #(.SCLK_HALF(2), .CAL_WAIT_CYC(50)) dsfi_asserts_inst (
		.hclk(hclk), .hresetn(hresetn), .sclk(link_bus.sclk),
		.cs_n(link_bus.cs_n), .sdi(link_bus.sdi),
		.load_strobe_n(link_bus.load_strobe_n),
		.reset_pin_n(link_bus.reset_pin_n), .voltage_en(voltage_en),
		.current_en(current_en));

	always #20 hclk = ~hclk;

	function automatic logic [15:0] lvl(input int r, input logic [15:0] k);
		return (r == 1 || r == 3 || r == 7 || r == 8) ? k ^ 16'h8000 : k;
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask

	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] v);
		@(posedge hclk);
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		hsize <= 3'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= v;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	task automatic idle;
		rd = 32'h1;
		for (int i = 0; i < 3000 && rd[0] !== 1'b0; i++)
			xfer(1'b0, 32'h8, 32'h0);
		chk(rd & 32'h1, 32'h0);
	endtask

	task automatic setc(input logic [31:0] v);
		ctl = v;
		xfer(1'b1, 32'h0, v);
		if (v[`DSFI_CTRL_RESET_BIT])
			@(posedge hclk);
		else
			idle();
	endtask

	task automatic send(input logic [1:0] a, input logic [4:0] r, input logic [15:0] v);
		xfer(1'b1, 32'h4, {8'h0, 1'b0, a, r, v});
		xfer(1'b1, 32'h0, ctl | 32'h2);
		idle();
	endtask

	task automatic final_report;
		$display("Checks %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	initial begin
		#2400000;
		n_mismatch++;
		final_report();
	end

	initial begin
		void'($urandom(32'h84F7FAC5));
		da = 2'($urandom);
		dev_addr <= da;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk(32'({hreadyout, hresp, voltage_en, current_en, pulldown_closed}),
			32'h10);
		xfer(1'b1, 32'hC, $urandom);
		xfer(1'b0, 32'hC, 32'h0);
		chk(rd, 32'h0);
		hsel <= 1'b0;
		xfer(1'b1, 32'h0, 32'h2);
		hsel <= 1'b1;
		xfer(1'b0, 32'h0, 32'h0);
		chk(rd, 32'(`DSFI_CTRL_RST_VAL));
		setc(32'h1);
		send(da, 5'h06, 16'h5AA5);
		chk(32'(cal_refresh_toggle), 32'h1);
		for (int r = 0; r < 11; r++) begin
			c = (r == 1) ? 16'h8000 : (r == 3) ? 16'h0000 : 16'($urandom);
			send(da, 5'h01, c);
			send(da, 5'h02, 16'h0110 | 16'(r));
			chk(32'(dac_code), 32'(c));
			chk(32'(output_level), 32'(lvl(r, c)));
			chk(32'(out_range), r);
			chk(32'({voltage_en, current_en, overrange_en}),
				32'({r < 4, r > 3 && r < 10, r < 4}));
		end
		setc(32'h9);
		d = ~c;
		send(da, 5'h01, d);
		send(da, 5'h01, d);
		chk(32'(dac_code), 32'(c));
		setc(32'h1);
		send(da, 5'h01, d);
		chk(32'(dac_code), 32'(d));
		lv = 5'($urandom);
		send(da, 5'h03, {10'h0, 1'b1, lv});
		send(da, 5'h04, 16'h0001);
		send(da, 5'h05, 16'h0002);
		chk(32'({programmed_supply_mode, supply_level}),
			32'({1'b1, lv}));
		chk(32'({pulldown_closed, neg_offset_en}), 32'h3);
		send(da ^ 2'h1, 5'h03, 16'h0000);
		chk(32'(supply_level), 32'(lv));
		setc(32'h0);
		send(da, 5'h04, 16'h0000);
		chk(32'({crc_error, pulldown_closed}), 32'h3);
		setc(32'h1);
		send(da, 5'h05, 16'h0003);
		chk(32'({crc_error, crc_disabled}), 32'h1);
		setc(32'h0);
		send(da, 5'h03, 16'h0000);
		send(da, 5'h05, 16'h0002);
		chk(32'({supply_level, crc_disabled, crc_error}), 32'h0);
		setc(32'h1);
		send(da, 5'h02, 16'h0102);
		chk(32'(voltage_en), 32'h1);
		send(da, 5'h06, 16'hA55A);
		chk(32'({dac_code, supply_level, pulldown_closed, neg_offset_en,
			voltage_en, programmed_supply_mode}), 32'h0);
		send(da, 5'h02, 16'h0104);
		chk(32'(current_en), 32'h1);
		setc(32'h5);
		chk(32'(current_en), 32'h0);
		setc(32'h1);
		send(da, 5'h04, 16'h0001);
		chk(32'(pulldown_closed), 32'h1);
		supply_ok <= 1'b0;
		@(posedge hclk);
		@(posedge hclk);
		chk(32'(pulldown_closed), 32'h0);
		supply_ok <= 1'b1;
		final_report();
	end
endmodule
